// >>> rtl/ssd_diag.sv
/*
  Status and diagnostics register bank: data-ready pulse, self-test
  control, error flags, flash write counter and two alarm channels.
  Assumes a serial front end that turns frames into word register
  strobes, and sensor logic that supplies samples and error events.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssd_consts.svh"

module ssd_diag
  import ssd_pkg::*;
#(
  parameter int ST_WAIT_CYC = `SSD_ST_WAIT_MS * (`SSD_CLK_HZ / 1000),
  parameter int ST_CNT_W = 22,
  parameter int PER_W = 24,
  parameter int DRDY_INIT_W = 16
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic DATA_UPDATE,
  input wire ssd_src_t SRC_RAW,
  input wire ssd_src_t SRC_FILTER_PIN,
  input wire ssd_err_in_t ERR_IN,
  input wire logic FLASH_WRITE,
  input wire logic [1:0] GPIO_OUT,
  input wire logic [1:0] GPIO_OE,
  output logic [1:0] DIO_OUT,
  output logic [1:0] DIO_OE,
  output logic ST_INTERNAL,
  output logic ST_POS_DRIVE,
  output logic ST_NEG_DRIVE
);

  localparam logic [ST_CNT_W-1:0] ST_LOAD = ST_CNT_W'(ST_WAIT_CYC);
  localparam logic [PER_W-1:0] DRDY_INIT = PER_W'(DRDY_INIT_W);

  logic [15:0] misc_q;
  logic [15:0] almctl_q;
  logic [15:0] err_q;
  logic [15:0] flash_q;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] period_q;
  logic [PER_W-1:0] width_q;
  logic [PER_W-1:0] pulse_q;
  logic have_per_q;
  ssd_st_state_t st_state_q;
  logic [ST_CNT_W-1:0] st_cnt_q;
  logic [1:0] alm_lvl;
  logic [1:0] dio_out_d;
  logic [1:0] dio_oe_d;
  wire [15:0] mag_rd [2];
  wire [15:0] smpl_rd [2];

  // Register strobes
  wire misc_wr = REG_WR && REG_ADDR == `SSD_ADDR_MISC_CTRL;
  wire almctl_wr = REG_WR && REG_ADDR == `SSD_ADDR_ALARM_CONTROL;
  wire rd_err = REG_RD && REG_ADDR == `SSD_ADDR_ERR_FLAGS;
  wire drdy_en = misc_q[`SSD_MISC_DRDY_EN];
  wire alm_en = almctl_q[`SSD_ALM_EN];
  wire alm_any = |alm_lvl;

  // Data-ready width: a quarter of the interval that just ended
  wire [PER_W-1:0] new_per = per_cnt_q + PER_W'(1);
  wire [PER_W-1:0] quarter = new_per >> 2;
  wire [PER_W-1:0] width_n = !have_per_q ? DRDY_INIT :
    (quarter == '0) ? PER_W'(1) : quarter;
  wire drdy_act = pulse_q != '0;

  // Internal self-test sequencing
  wire st_start = misc_wr && REG_WDATA[`SSD_MISC_ST_INT] && st_state_q == SSD_ST_IDLE;
  wire st_done = st_state_q == SSD_ST_RUN && st_cnt_q == ST_CNT_W'(1);
  wire ssd_st_state_t st_next = st_start ? SSD_ST_RUN : st_done ? SSD_ST_IDLE : st_state_q;

  // Error flags: hardware sets win over the clearing read
  wire [15:0] err_set = {6'h00, alm_lvl[1], alm_lvl[0], 2'b00,
    st_done && ERR_IN.st_fail, 1'b0, ERR_IN.spi_fail, ERR_IN.ctrl_fail, 2'b00};
  wire [15:0] err_auto = {11'h000, ERR_IN.rate_over, 2'b00, ERR_IN.sup_hi, ERR_IN.sup_lo};
  wire [15:0] err_keep = rd_err ? 16'h0000 : (err_q & `SSD_ERR_STICKY_MASK);
  wire [15:0] err_d = err_keep | err_set | err_auto;

  wire [15:0] flash_d = (flash_q == `SSD_FLASH_CNT_MAX) ? 16'h0000 : flash_q + 16'h0001;

  wire [15:0] misc_rd = misc_q | {5'h00, ST_INTERNAL, 10'h000};
  wire [15:0] rd_mux =
    (REG_ADDR == `SSD_ADDR_FLASH_CNT) ? flash_q :
    (REG_ADDR == `SSD_ADDR_MISC_CTRL) ? misc_rd :
    (REG_ADDR == `SSD_ADDR_ERR_FLAGS) ? err_q :
    (REG_ADDR == `SSD_ADDR_ALARM_CONTROL) ? almctl_q :
    (REG_ADDR == `SSD_ADDR_ALARM1_THRESHOLD) ? mag_rd[0] :
    (REG_ADDR == `SSD_ADDR_ALARM2_THRESHOLD) ? mag_rd[1] :
    (REG_ADDR == `SSD_ADDR_ALARM1_SAMPLE_COUNT) ? smpl_rd[0] :
    (REG_ADDR == `SSD_ADDR_ALARM2_SAMPLE_COUNT) ? smpl_rd[1] : 16'h0000;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= rd_mux;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      misc_q <= `SSD_MISC_RESET;
      almctl_q <= `SSD_ALM_RESET;
      err_q <= `SSD_ERR_RESET;
      flash_q <= `SSD_FLASH_RESET;
    end
    else
    begin
      if (misc_wr)
        misc_q <= REG_WDATA & `SSD_MISC_WMASK;
      if (almctl_wr)
        almctl_q <= REG_WDATA & `SSD_ALARM_CONTROL_WMASK;
      err_q <= err_d;
      if (FLASH_WRITE)
        flash_q <= flash_d;
    end
  end

  // Update interval measure; saturates so a stalled source cannot wrap
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      per_cnt_q <= '0;
      period_q <= '0;
      width_q <= '0;
      have_per_q <= 1'b0;
      pulse_q <= '0;
    end
    else if (DATA_UPDATE)
    begin
      per_cnt_q <= '0;
      period_q <= new_per;
      width_q <= width_n;
      have_per_q <= 1'b1;
      pulse_q <= drdy_en ? width_n : '0;
    end
    else
    begin
      if (per_cnt_q != '1)
        per_cnt_q <= new_per;
      if (drdy_act)
        pulse_q <= pulse_q - PER_W'(1);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_state_q <= SSD_ST_IDLE;
      st_cnt_q <= '0;
      ST_INTERNAL <= 1'b0;
      ST_POS_DRIVE <= 1'b0;
      ST_NEG_DRIVE <= 1'b0;
    end
    else
    begin
      st_state_q <= st_next;
      ST_INTERNAL <= st_next == SSD_ST_RUN;
      if (st_start)
        st_cnt_q <= ST_LOAD;
      else if (st_state_q == SSD_ST_RUN)
        st_cnt_q <= st_cnt_q - ST_CNT_W'(1);
      ST_POS_DRIVE <= misc_q[`SSD_MISC_ST_POS];
      ST_NEG_DRIVE <= misc_q[`SSD_MISC_ST_NEG];
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_ch
      localparam logic [5:0] MAG_A = (i == 0) ? `SSD_ADDR_ALARM1_THRESHOLD : `SSD_ADDR_ALARM2_THRESHOLD;
      localparam logic [5:0] SMPL_A = (i == 0) ? `SSD_ADDR_ALARM1_SAMPLE_COUNT : `SSD_ADDR_ALARM2_SAMPLE_COUNT;
      localparam int SH = i * `SSD_ALM_CH_STEP;
      logic [15:0] mag_q;
      logic [7:0] smpl_q;
      ssd_alm_cfg_t cfg;

      always_ff @(posedge REF_CLK or posedge RST)
      begin
        if (RST)
        begin
          mag_q <= `SSD_ALM_RESET;
          smpl_q <= 8'h00;
        end
        else
        begin
          if (REG_WR && REG_ADDR == MAG_A)
            mag_q <= REG_WDATA & `SSD_ALM_MAG_WMASK;
          if (REG_WR && REG_ADDR == SMPL_A)
            smpl_q <= REG_WDATA[7:0];
        end
      end

      assign mag_rd[i] = mag_q;
      assign smpl_rd[i] = {8'h00, smpl_q};
      assign cfg.roc = almctl_q[`SSD_ALM_ROC1 + SH];
      assign cfg.src = almctl_q[`SSD_ALM_SRC1 + SH +: 3];
      assign cfg.use_filter_pin = almctl_q[`SSD_ALM_FILTER_PIN];
      assign cfg.gt = mag_q[`SSD_ALM_MAG_GT];
      assign cfg.mag = mag_q[13:0];
      assign cfg.nds = smpl_q;

      ssd_alarm_ch u_alarm (
        .clk(REF_CLK),
        .rst(RST),
        .sample_en(DATA_UPDATE),
        .cfg(cfg),
        .raw(SRC_RAW),
        .filter_pin(SRC_FILTER_PIN),
        .alarm_q(alm_lvl[i])
      );

      // Line arbitration; idle level of a pulse is the inverse of its active level
      wire dr_here = drdy_en && misc_q[`SSD_MISC_DRDY_LINE] == 1'(i);
      wire al_here = alm_en && almctl_q[`SSD_ALM_LINE] == 1'(i);
      assign dio_out_d[i] = dr_here ? (drdy_act ~^ misc_q[`SSD_MISC_DRDY_POL]) :
        al_here ? (alm_any ~^ almctl_q[`SSD_ALM_POL]) : GPIO_OUT[i];
      assign dio_oe_d[i] = dr_here | al_here | GPIO_OE[i];
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      DIO_OUT <= 2'b00;
      DIO_OE <= 2'b00;
    end
    else
    begin
      DIO_OUT <= dio_out_d;
      DIO_OE <= dio_oe_d;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  drdy_pulse_a: assert property ((DATA_UPDATE && drdy_en) |=> drdy_act ##1
      DIO_OUT[$past(misc_q[0], 2)] == $past(misc_q[1], 2))
    else $error("no data-ready pulse after update");
  drdy_duty_a: assert property ((DATA_UPDATE && drdy_en && have_per_q && new_per >= 8) |=>
      (32'(width_q) * 100 >= 32'(period_q) * `SSD_DRDY_DUTY_LO &&
       32'(width_q) * 100 <= 32'(period_q) * `SSD_DRDY_DUTY_HI))
    else $error("data-ready duty out of range");
  drdy_line_a: assert property ((drdy_en && !misc_wr) |=> DIO_OE[misc_q[0]])
    else $error("data-ready line not driven");
  drdy_pol_a: assert property ((drdy_en && !misc_q[0]) |=>
      DIO_OUT[0] == ($past(drdy_act) ~^ $past(misc_q[1])))
    else $error("data-ready polarity wrong");
  drdy_prio_a: assert property ((drdy_en && alm_en && misc_q[0] == almctl_q[0] && !drdy_act
      && !misc_wr) |=> DIO_OUT[$past(misc_q[0])] == !$past(misc_q[1]))
    else $error("alarm overrode data-ready");
  st_result_a: assert property (st_done |=> !ST_INTERNAL && misc_rd[10] == 1'b0 &&
      err_q[5] == ($past(ERR_IN.st_fail) || ($past(err_q[5]) && !$past(rd_err))))
    else $error("self-test result not posted");
  st_ext_a: assert property ((misc_wr && REG_WDATA[9:8] == 2'b01) |=> ##1
      (ST_POS_DRIVE && !ST_NEG_DRIVE))
    else $error("external self-test drive wrong");
  err_clear_a: assert property ((rd_err && err_set == 16'h0000) |=>
      (err_q & `SSD_ERR_STICKY_MASK) == 16'h0000)
    else $error("read did not clear latched flags");
  err_auto_a: assert property ((!ERR_IN.sup_hi && !ERR_IN.sup_lo && !ERR_IN.rate_over) |=>
      (err_q & ~`SSD_ERR_STICKY_MASK) == 16'h0000)
    else $error("self-clearing flag stuck");
  err_latch_a: assert property ((alm_lvl[0] && !rd_err) |=> err_q[8] ##1
      ($past(rd_err) || err_q[8]))
    else $error("alarm flag not latched");
  flash_wrap_a: assert property ((FLASH_WRITE && flash_q == `SSD_FLASH_CNT_MAX) |=>
      flash_q == 16'h0000)
    else $error("flash counter did not wrap");
  flash_inc_a: assert property ((FLASH_WRITE && flash_q != `SSD_FLASH_CNT_MAX) |=>
      flash_q == $past(flash_q) + 16'h0001)
    else $error("flash counter did not count");

  drdy_line1_c: cover property (drdy_en && misc_q[0] && DATA_UPDATE ##1 drdy_act);
  st_fail_c: cover property (st_done && ERR_IN.st_fail);
  flash_wrap_c: cover property (FLASH_WRITE && flash_q == `SSD_FLASH_CNT_MAX);
  alarm_both_c: cover property (alm_lvl == 2'b11);

endmodule : ssd_diag

`default_nettype wire

// >>> rtl/ssd_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the
  status and diagnostics register bank. Assumes nothing; definitions only.
*/
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH

`define SSD_ADDR_FLASH_CNT 6'h00
`define SSD_ADDR_ALARM1_THRESHOLD 6'h20
`define SSD_ADDR_ALARM2_THRESHOLD 6'h22
`define SSD_ADDR_ALARM1_SAMPLE_COUNT 6'h24
`define SSD_ADDR_ALARM2_SAMPLE_COUNT 6'h26
`define SSD_ADDR_ALARM_CONTROL 6'h28
`define SSD_ADDR_MISC_CTRL 6'h34
`define SSD_ADDR_ERR_FLAGS 6'h3C

`define SSD_MISC_DRDY_LINE 0
`define SSD_MISC_DRDY_POL 1
`define SSD_MISC_DRDY_EN 2
`define SSD_MISC_ST_POS 8
`define SSD_MISC_ST_NEG 9
`define SSD_MISC_ST_INT 10
`define SSD_MISC_WMASK 16'h0307
`define SSD_MISC_RESET 16'h0000

`define SSD_ERR_STICKY_MASK 16'h032C
`define SSD_ERR_ST_FAIL 5
`define SSD_ERR_ALM1 8
`define SSD_ERR_RESET 16'h0000

`define SSD_ALM_LINE 0
`define SSD_ALM_POL 1
`define SSD_ALM_EN 2
`define SSD_ALM_FILTER_PIN 4
`define SSD_ALM_SRC1 8
`define SSD_ALM_ROC1 11
`define SSD_ALM_CH_STEP 4
`define SSD_ALARM_CONTROL_WMASK 16'hFF17
`define SSD_ALM_MAG_WMASK 16'hBFFF
`define SSD_ALM_MAG_GT 15
`define SSD_ALM_RESET 16'h0000

`define SSD_SRC_SUPPLY 3'h1
`define SSD_SRC_GYRO 3'h2
`define SSD_SRC_AUX 3'h5
`define SSD_SRC_TEMP 3'h6

`define SSD_FLASH_CNT_MAX 16'h7FFF
`define SSD_FLASH_RESET 16'h0000

`define SSD_CLK_HZ 100000000
`define SSD_ST_WAIT_MS 35
`define SSD_DRDY_DUTY_LO 15
`define SSD_DRDY_DUTY_HI 35

`endif

// >>> rtl/ssd_pkg.sv
/*
  Types of the status and diagnostics register bank.
  Assumes the constants header is compiled alongside.
*/
package ssd_pkg;

  typedef struct packed {
    logic [13:0] temp;
    logic [13:0] aux;
    logic [13:0] rate;
    logic [13:0] supply;
  } ssd_src_t;

  typedef struct packed {
    logic roc;
    logic [2:0] src;
    logic use_filter_pin;
    logic gt;
    logic [13:0] mag;
    logic [7:0] nds;
  } ssd_alm_cfg_t;

  typedef struct packed {
    logic sup_hi;
    logic sup_lo;
    logic rate_over;
    logic spi_fail;
    logic ctrl_fail;
    logic st_fail;
  } ssd_err_in_t;

  typedef enum logic [1:0] {
    SSD_ST_IDLE = 2'b01,
    SSD_ST_RUN = 2'b10
  } ssd_st_state_t;

endpackage : ssd_pkg

// >>> rtl/ssd_alarm_ch.sv
/*
  One alarm channel: static level or averaged rate-of-change compare.
  Assumes sample_en pulses once per output data update.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssd_consts.svh"

module ssd_alarm_ch
  import ssd_pkg::*;
#(
  parameter int ACC_W = 26
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_en,
  input wire ssd_alm_cfg_t cfg,
  input wire ssd_src_t raw,
  input wire ssd_src_t filter_pin,
  output logic alarm_q
);

  logic signed [15:0] prev_q;
  logic have_q;
  logic signed [ACC_W-1:0] sum_q;
  logic [7:0] cnt_q;

  wire ssd_src_t src = cfg.use_filter_pin ? filter_pin : raw;
  wire sel_sup = cfg.src == `SSD_SRC_SUPPLY;
  wire sel_gyro = cfg.src == `SSD_SRC_GYRO;
  wire sel_aux = cfg.src == `SSD_SRC_AUX;
  wire sel_temp = cfg.src == `SSD_SRC_TEMP;
  wire valid = sel_sup | sel_gyro | sel_aux | sel_temp;
  wire [13:0] pick = sel_sup ? src.supply : sel_gyro ? src.rate : sel_aux ? src.aux : src.temp;
  // Rate data is two's complement, the other sources are straight binary
  wire signed [15:0] sv = {{2{sel_gyro & pick[13]}}, pick};
  wire signed [15:0] mv = {{2{sel_gyro & cfg.mag[13]}}, cfg.mag};
  wire signed [16:0] delta = {sv[15], sv} - {prev_q[15], prev_q};
  wire signed [ACC_W-1:0] sum_n = sum_q + ACC_W'(delta);
  wire [8:0] nds = (cfg.nds == 8'h00) ? 9'h001 : {1'b0, cfg.nds};
  // Mean against threshold without a divider: sum against mag times count
  wire signed [ACC_W-1:0] lim = ACC_W'(mv * $signed(nds));
  wire [7:0] cnt_n = cnt_q + 8'h01;
  wire last = {1'b0, cnt_n} >= nds;
  wire hit_lvl = cfg.gt ? (sv > mv) : (sv < mv);
  wire hit_roc = cfg.gt ? (sum_n > lim) : (sum_n < lim);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= 16'sh0000;
      have_q <= 1'b0;
      sum_q <= '0;
      cnt_q <= 8'h00;
      alarm_q <= 1'b0;
    end
    else if (!valid)
    begin
      have_q <= 1'b0;
      sum_q <= '0;
      cnt_q <= 8'h00;
      alarm_q <= 1'b0;
    end
    else if (sample_en)
    begin
      prev_q <= sv;
      have_q <= 1'b1;
      if (!cfg.roc)
        alarm_q <= hit_lvl;
      else if (have_q && last)
      begin
        alarm_q <= hit_roc;
        sum_q <= '0;
        cnt_q <= 8'h00;
      end
      else if (have_q)
      begin
        sum_q <= sum_n;
        cnt_q <= cnt_n;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  alarm_level_a: assert property ((sample_en && valid && !cfg.roc) |=> alarm_q == $past(hit_lvl))
    else $error("static alarm does not follow compare");
  alarm_hold_a: assert property ((sample_en && valid && cfg.roc && have_q && !last) ##1 !sample_en
      |-> $stable(alarm_q))
    else $error("rate alarm changed before averaging done");
  alarm_off_a: assert property (!valid |=> !alarm_q)
    else $error("disabled alarm channel active");

endmodule : ssd_alarm_ch

`default_nettype wire

// >>> test/ssd_host.sv
/*
  Host model: word register reads and writes on the strobe port.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module ssd_host
(
  input wire logic clk,
  output logic [5:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial
  begin
    addr = 6'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    // Released bus shows garbage, not the last value
    addr = ~a;
    wdata = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
    int n;
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    n = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    d = (rvalid === 1'b1) ? rdata : 16'hXXXX;
  endtask : rd_reg
endmodule : ssd_host
`default_nettype wire

// >>> test/tb.sv
/*
  Self-checking bench of the status and diagnostics bank.
  Assumes the host model and a short self-test wait of 50 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module tb
  import ssd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic upd = 1'b0;
  logic fw = 1'b0;
  logic [1:0] g_out = 2'h0;
  logic [1:0] g_oe = 2'h0;
  ssd_src_t raw = '0;
  ssd_src_t filter_pin = '0;
  ssd_err_in_t err = '0;
  logic [5:0] a;
  logic w, r, rv, st_i, st_p, st_n;
  logic [15:0] wd, rdat;
  logic [1:0] d_out, d_oe;
  int err_count = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  ssd_diag #(.ST_WAIT_CYC(50)) uut (.REF_CLK(clk), .RST(rst), .REG_ADDR(a),
    .REG_WR(w), .REG_RD(r), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RVALID(rv),
    .DATA_UPDATE(upd), .SRC_RAW(raw), .SRC_FILTER_PIN(filter_pin), .ERR_IN(err),
    .FLASH_WRITE(fw), .GPIO_OUT(g_out), .GPIO_OE(g_oe), .DIO_OUT(d_out),
    .DIO_OE(d_oe), .ST_INTERNAL(st_i), .ST_POS_DRIVE(st_p), .ST_NEG_DRIVE(st_n));

  ssd_host host (.clk(clk), .addr(a), .wr(w), .rd(r), .wdata(wd),
    .rdata(rdat), .rvalid(rv));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [5:0] ad, input logic [15:0] exp);
    logic [15:0] v;
    host.rd_reg(ad, v);
    chk(v, exp);
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic pulse_upd;
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    tick(3);
  endtask : pulse_upd

  task automatic pulse_fw(input int n);
    fw = 1'b1;
    tick(n);
    fw = 1'b0;
  endtask : pulse_fw

  task automatic t_reset;
    rchk(6'h34, 16'h0000);
    rchk(6'h3C, 16'h0000);
    host.wr_reg(6'h3C, 16'hFFFF);
    host.wr_reg(6'h00, 16'h1234);
    rchk(6'h3C, 16'h0000);
    rchk(6'h00, 16'h0000);
    rchk(6'h10, 16'h0000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_misc;
    host.wr_reg(6'h34, 16'hFBFF);
    rchk(6'h34, 16'h0307);
    chk({14'h0, st_n, st_p}, 16'h0003);
    // One stimulus at a time, so a swapped pair shows
    host.wr_reg(6'h34, 16'h0200);
    tick(1);
    chk({14'h0, st_n, st_p}, 16'h0002);
    host.wr_reg(6'h34, 16'h0100);
    tick(1);
    chk({14'h0, st_n, st_p}, 16'h0001);
    host.wr_reg(6'h34, 16'h0000);
    tick(1);
    chk({14'h0, st_n, st_p}, 16'h0000);
    g_oe = 2'h3;
    g_out = 2'h2;
    tick(2);
    chk({12'h0, d_oe, d_out}, 16'h000E);
    $display("control test done");
  endtask : t_misc

  // Four update periods of 40 cycles; only the last is measured
  task automatic t_drdy(input logic [15:0] c, input int ln, input logic act,
    input logic en);
    int n;
    n = 0;
    host.wr_reg(6'h34, c);
    for (int p = 0; p < 4; p++)
      for (int i = 0; i < 40; i++)
      begin
        tick(1);
        upd = (i == 0);
        if (p == 3 && d_out[ln] === act && d_oe[ln] === 1'b1)
          n++;
      end
    if (en)
      chk(16'(n * 100 >= 15 * 40 && n * 100 <= 35 * 40), 16'h0001);
    else
      chk(16'(n), 16'h0000);
    $display("data-ready test done");
  endtask : t_drdy

  task automatic t_selftest;
    err.st_fail = 1'b1;
    host.wr_reg(6'h34, 16'h0400);
    chk({15'h0, st_i}, 16'h0001);
    rchk(6'h34, 16'h0400);
    // Still running near the end of the 50-cycle wait
    tick(40);
    chk({15'h0, st_i}, 16'h0001);
    tick(20);
    chk({15'h0, st_i}, 16'h0000);
    rchk(6'h3C, 16'h0020);
    rchk(6'h3C, 16'h0000);
    err.st_fail = 1'b0;
    $display("self-test test done");
  endtask : t_selftest

  task automatic t_flags;
    err.rate_over = 1'b1;
    err.spi_fail = 1'b1;
    err.ctrl_fail = 1'b1;
    tick(1);
    err.spi_fail = 1'b0;
    err.ctrl_fail = 1'b0;
    tick(2);
    rchk(6'h3C, 16'h001C);
    tick(2);
    rchk(6'h3C, 16'h0010);
    err.rate_over = 1'b0;
    err.sup_hi = 1'b1;
    tick(2);
    rchk(6'h3C, 16'h0002);
    err.sup_hi = 1'b0;
    err.sup_lo = 1'b1;
    tick(2);
    rchk(6'h3C, 16'h0001);
    err.sup_lo = 1'b0;
    $display("flag test done");
  endtask : t_flags

  task automatic t_alarm;
    logic [15:0] v;
    raw.rate = 14'h00C8;
    raw.supply = 14'h000A;
    host.wr_reg(6'h20, 16'h8064);
    host.wr_reg(6'h22, 16'h0032);
    host.wr_reg(6'h28, 16'h1200);
    pulse_upd;
    rchk(6'h3C, 16'h0300);
    raw.rate = 14'h0032;
    raw.supply = 14'h0064;
    pulse_upd;
    rchk(6'h3C, 16'h0300);
    rchk(6'h3C, 16'h0000);
    // Filtered supply low while the raw one is not
    filter_pin.supply = 14'h0014;
    host.wr_reg(6'h28, 16'h1210);
    pulse_upd;
    rchk(6'h3C, 16'h0200);
    // Slope of 20 is below 30 while every level is far above it
    host.wr_reg(6'h20, 16'h001E);
    host.wr_reg(6'h24, 16'h0002);
    host.wr_reg(6'h28, 16'h0A00);
    for (int k = 0; k < 4; k++)
    begin
      raw.rate = 14'(200 + k * 20);
      pulse_upd;
    end
    host.rd_reg(6'h3C, v);
    rchk(6'h3C, 16'h0100);
    // Line 0: general I/O high, alarm active low, data-ready idle high
    g_oe = 2'h3;
    g_out = 2'h3;
    host.wr_reg(6'h28, 16'h0A04);
    tick(2);
    chk({12'h0, d_oe, d_out}, 16'h000E);
    host.wr_reg(6'h34, 16'h0004);
    tick(2);
    chk({12'h0, d_oe, d_out}, 16'h000F);
    $display("alarm test done");
  endtask : t_alarm

  task automatic t_flash;
    pulse_fw(5);
    rchk(6'h00, 16'h0005);
    pulse_fw(32765);
    rchk(6'h00, 16'h0002);
    $display("flash counter test done");
  endtask : t_flash

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_misc;
    t_drdy(16'h0007, 1, 1'b1, 1'b1);
    t_drdy(16'h0004, 0, 1'b0, 1'b1);
    t_drdy(16'h0002, 0, 1'b1, 1'b0);
    t_selftest;
    t_flags;
    t_alarm;
    t_flash;
    end_of_test;
  end

  // Whole run needs a little under half of this span
  initial
  begin
    #800000;
    err_count++;
    end_of_test;
  end
endmodule : tb
`default_nettype wire
